// [hdl/msc_if.sv]
// Interfaces between the control core, serial link and SAR engine
`timescale 1ns/1ps
interface msc_ser_if;
	logic [msc_pkg::CFG_W-1:0] cfg_word;
	logic cfg_done;
	logic acq_lvl;
	logic sdo_bit;
	logic [msc_pkg::RES_W-1:0] result;
	modport link (output cfg_word, cfg_done, acq_lvl, sdo_bit, input result);
	modport ctrl (input cfg_word, cfg_done, acq_lvl, sdo_bit, output result);
endinterface : msc_ser_if

interface msc_sar_if;
	logic start;
	logic comp_hi;
	logic done;
	logic [msc_pkg::RES_W-1:0] result;
	logic [msc_pkg::RES_W-1:0] dac_code;
	modport core (input start, comp_hi, output done, result, dac_code);
	modport ctrl (output start, comp_hi, input done, result, dac_code);
endinterface : msc_sar_if

// [hdl/msc_pkg.sv]
// Shared constants and types of the serial ADC control block
package msc_pkg;
	localparam int RES_W = 16;
	localparam int CFG_W = 8;
	localparam int CNT_W = 5;
	localparam int STEP_W = 5;
	localparam int IDX_W = 4;
	localparam int CLK_PERIOD_PS = 8000;
	localparam int CONV_TIME_US = 4;
	localparam int ACQ_MIN_US = 4;
	localparam int BIT_CYC = CONV_TIME_US * 1000000 / CLK_PERIOD_PS / RES_W;
	localparam int ACQ_MIN_CYC =
		(ACQ_MIN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [CNT_W-1:0] CFG_RISES = 5'h08;
	localparam logic [CNT_W-1:0] ACQ_FALL = 5'h06;
	localparam logic [CNT_W-1:0] OUT_BITS = 5'h10;
	localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
	localparam logic [IDX_W-1:0] IDX_LAST = 4'hF;
	localparam logic [STEP_W-1:0] BIT_LAST = STEP_W'(BIT_CYC - 1);
	localparam logic [RES_W-1:0] SAR_MSB = 16'h8000;
	localparam logic [RES_W-1:0] RES_ZERO = 16'h0000;
	localparam logic [CFG_W-1:0] CFG_RST = 8'h00;
	// Field positions, first bit shifted in lands in the top bit
	localparam int F_SGL = 7;
	localparam int F_ODD = 6;
	localparam int F_SEL_HI = 5;
	localparam int F_SEL_LO = 4;
	localparam int F_UNI = 3;
	localparam int F_GAIN = 2;
	localparam int F_NAP = 1;
	localparam int F_SLEEP = 0;
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'h1,
		ST_ACQ = 3'h2,
		ST_CONV = 3'h4
	} msc_state_t;
endpackage : msc_pkg

// [hdl/msc_sar.sv]
// Successive approximation engine, one comparator decision per bit
`timescale 1ns/1ps
module msc_sar (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Control side
	msc_sar_if.core sar
);
	import msc_pkg::*;

	localparam int SAR_LEN = RES_W * BIT_CYC;
	logic run_q;
	logic done_q;
	logic [IDX_W-1:0] idx_q;
	logic [STEP_W-1:0] step_q;
	logic [RES_W-1:0] trial_q;
	logic [RES_W-1:0] result_q;
	logic [RES_W-1:0] bit_m;
	logic [RES_W-1:0] kept;
	logic decide;

	assign bit_m = SAR_MSB >> idx_q;
	assign kept = sar.comp_hi ? trial_q : (trial_q & ~bit_m);
	assign decide = run_q && (step_q == BIT_LAST);

	// Trial code walks from the top bit down
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			run_q <= 1'b0;
			idx_q <= '0;
			step_q <= '0;
			trial_q <= RES_ZERO;
		end
		else if (sar.start && !run_q)
		begin
			run_q <= 1'b1;
			idx_q <= '0;
			step_q <= '0;
			trial_q <= SAR_MSB;
		end
		else if (decide)
		begin
			step_q <= '0;
			if (idx_q == IDX_LAST)
			begin
				run_q <= 1'b0;
				trial_q <= kept;
			end
			else
			begin
				idx_q <= idx_q + 4'h1;
				trial_q <= kept | (bit_m >> 1);
			end
		end
		else if (run_q)
			step_q <= step_q + 5'h01;
	end

	// Final word and completion pulse
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			done_q <= 1'b0;
			result_q <= RES_ZERO;
		end
		else
		begin
			done_q <= decide && (idx_q == IDX_LAST);
			if (decide && (idx_q == IDX_LAST))
				result_q <= kept;
		end
	end

	assign sar.done = done_q;
	assign sar.result = result_q;
	assign sar.dac_code = trial_q;

	a_sar_msb_first: assert property (@(posedge clk) disable iff (!rst_b)
		sar.start && !run_q |=> sar.dac_code == SAR_MSB)
		else $error("first trial is not the top bit");
	a_sar_length: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(run_q) |-> ##[SAR_LEN:SAR_LEN] done_q)
		else $error("conversion did not take one decision per bit");
endmodule : msc_sar

// [hdl/msc_serial.sv]
// Serial shift logic running on the host serial clock
`timescale 1ns/1ps
module msc_serial (
	// Link clock and frame reset
	input wire logic sck,
	input wire logic link_rst_b,
	// Serial data in
	input wire logic sdi,
	// Control side
	msc_ser_if.link ser
);
	import msc_pkg::*;

	logic [CNT_W-1:0] rise_cnt_q;
	logic [CNT_W-1:0] fall_cnt_q;
	logic [CFG_W-1:0] cfg_q;
	logic cfg_done_q;
	logic acq_q;
	logic [CNT_W-1:0] out_idx;

	// Capture on rising edges, later bits ignored until frame reset
	always_ff @(posedge sck or negedge link_rst_b)
	begin
		if (!link_rst_b)
		begin
			rise_cnt_q <= '0;
			cfg_q <= CFG_RST;
			cfg_done_q <= 1'b0;
		end
		else if (rise_cnt_q < CFG_RISES)
		begin
			cfg_q <= {cfg_q[CFG_W-2:0], sdi};
			rise_cnt_q <= rise_cnt_q + CNT_ONE;
			cfg_done_q <= (rise_cnt_q == CFG_RISES - CNT_ONE);
		end
	end

	// Launch on falling edges; sixth one opens acquisition
	always_ff @(negedge sck or negedge link_rst_b)
	begin
		if (!link_rst_b)
		begin
			fall_cnt_q <= '0;
			acq_q <= 1'b0;
		end
		else if (fall_cnt_q < OUT_BITS)
		begin
			fall_cnt_q <= fall_cnt_q + CNT_ONE;
			acq_q <= acq_q | (fall_cnt_q == ACQ_FALL - CNT_ONE);
		end
	end

	// Previous result, top bit first, zeros once exhausted
	assign out_idx = OUT_BITS - CNT_ONE - fall_cnt_q;
	assign ser.sdo_bit = (fall_cnt_q < OUT_BITS) ?
		ser.result[out_idx[IDX_W-1:0]] : 1'b0;
	assign ser.cfg_word = cfg_q;
	assign ser.cfg_done = cfg_done_q;
	assign ser.acq_lvl = acq_q;
endmodule : msc_serial

// [hdl/msc_top.sv]
// Control and serial interface of an eight channel SAR converter
// How it works
// - Serial output is driven only while the read enable is low.
// - A rising convert start edge begins a new conversion.
// - Eight config bits enter on the first eight rising serial clocks.
// - Acquisition starts on the sixth falling serial clock of the word.
// - The convert start edge ends acquisition and puts the sample in hold.
// - Convert start edges during a conversion are ignored.
// - Result bits resolve top bit first, one comparator decision each.
// - The full 16-bit result moves to the output word at the end.
// - Unipolar ranges give natural binary codes.
// - Bipolar ranges give two's complement codes.
// - Bipolar top code 7FFF, code just below zero FFFF.
// - Channel and range both come from each config word.
// - Busy stays low during conversion and goes high at completion.
// - Bits launch on falling and are caught on rising serial clock.
// - The previous result shifts out while the next config shifts in.
// - The first four config bits select the multiplexer setting.
`timescale 1ns/1ps
module msc_top (
	// System clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Serial link from the host
	input wire logic sck,
	input wire logic sdi,
	input wire logic rd_b,
	output logic sdo_o,
	output logic sdo_oe,
	// Conversion control
	input wire logic convert_start,
	output logic busy_b,
	// Analog front end
	input wire logic comp_hi,
	output logic [msc_pkg::RES_W-1:0] dac_code,
	output logic sample_hold,
	output logic single_or_differential_select,
	output logic odd_sign,
	output logic [1:0] chan_sel,
	output logic range_unipolar,
	output logic range_gain,
	// Power down requests and status
	output logic nap_mode,
	output logic sleep_mode,
	output logic acq_short,
	output logic [msc_pkg::RES_W-1:0] result_word
);
	import msc_pkg::*;

	localparam int NSYNC = 4;
	localparam int SY_CONV = 0;
	localparam int SY_COMP = 1;
	localparam int SY_CFG = 2;
	localparam int SY_ACQ = 3;
	localparam int ACQ_W = 10;
	localparam logic [ACQ_W-1:0] ACQ_MIN = ACQ_W'(ACQ_MIN_CYC);

	msc_ser_if ser ();
	msc_sar_if sar ();

	msc_state_t state_q;
	msc_state_t state_d;
	logic [NSYNC-1:0] sync_in;
	logic [NSYNC-1:0] meta_q;
	logic [NSYNC-1:0] sync_q;
	logic [NSYNC-1:0] prev_q;
	logic conv_edge;
	logic cfg_edge;
	logic acq_edge;
	logic launch;
	logic busy_b_q;
	logic hold_q;
	logic link_en_q;
	logic acq_short_q;
	logic [ACQ_W-1:0] acq_cnt_q;
	logic [CFG_W-1:0] cfg_act_q;
	logic [RES_W-1:0] result_q;

	function automatic logic rose(input logic now_v, input logic was_v);
		return now_v & ~was_v;
	endfunction : rose

	function automatic logic [RES_W-1:0] code_word(
		input logic [RES_W-1:0] raw,
		input logic uni
	);
		// Bipolar flips the top bit of the offset code
		if (uni)
			return raw;
		return {~raw[RES_W-1], raw[RES_W-2:0]};
	endfunction : code_word

	// Serial link on its own clock, held cleared during a conversion
	msc_serial u_serial (
		.sck(sck),
		.link_rst_b(link_en_q),
		.sdi(sdi),
		.ser(ser)
	);

	msc_sar u_sar (
		.clk(clk),
		.rst_b(rst_b),
		.sar(sar)
	);

	// Pins and link levels into the system clock domain
	assign sync_in[SY_CONV] = convert_start;
	assign sync_in[SY_COMP] = comp_hi;
	assign sync_in[SY_CFG] = ser.cfg_done;
	assign sync_in[SY_ACQ] = ser.acq_lvl;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= sync_in;
			sync_q <= meta_q;
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			prev_q <= '0;
		else
			prev_q <= sync_q;
	end

	assign conv_edge = rose(sync_q[SY_CONV], prev_q[SY_CONV]);
	assign cfg_edge = rose(sync_q[SY_CFG], prev_q[SY_CFG]);
	assign acq_edge = rose(sync_q[SY_ACQ], prev_q[SY_ACQ]);
	assign launch = conv_edge && (state_q != ST_CONV);

	// Conversion sequence
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_IDLE:
			begin
				if (conv_edge)
					state_d = ST_CONV;
				else if (acq_edge)
					state_d = ST_ACQ;
			end
			ST_ACQ:
			begin
				if (conv_edge)
					state_d = ST_CONV;
			end
			ST_CONV:
			begin
				if (sar.done)
					state_d = ST_IDLE;
			end
			default:
				state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			state_q <= ST_IDLE;
		else
			state_q <= state_d;
	end

	assign sar.start = launch;
	assign sar.comp_hi = sync_q[SY_COMP];

	// Busy low from launch until the result is loaded
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			busy_b_q <= 1'b1;
		else
			busy_b_q <= (state_d != ST_CONV);
	end

	// Track or hold of the sampler
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			hold_q <= 1'b0;
		else if (launch)
			hold_q <= 1'b1;
		else if (acq_edge && (state_q != ST_CONV))
			hold_q <= 1'b0;
	end

	// Frame reset of the link lags the result load by one cycle
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			link_en_q <= 1'b0;
		else
			link_en_q <= (state_q != ST_CONV);
	end

	// Acquisition length seen at launch, flagged when too short
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			acq_cnt_q <= '0;
		else if (state_q != ST_ACQ)
			acq_cnt_q <= '0;
		else if (acq_cnt_q < ACQ_MIN)
			acq_cnt_q <= acq_cnt_q + 10'h001;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			acq_short_q <= 1'b0;
		else if (launch)
			acq_short_q <= (acq_cnt_q < ACQ_MIN);
	end

	// Configuration word takes effect once all eight bits are in
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			cfg_act_q <= CFG_RST;
		else if (cfg_edge && (state_q != ST_CONV))
			cfg_act_q <= ser.cfg_word;
	end

	// Result coding by range
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			result_q <= RES_ZERO;
		else if (sar.done)
			result_q <= code_word(sar.result, cfg_act_q[F_UNI]);
	end

	assign ser.result = result_q;

	// Multiplexer, range and power settings
	assign single_or_differential_select = cfg_act_q[F_SGL];
	assign odd_sign = cfg_act_q[F_ODD];
	assign chan_sel = cfg_act_q[F_SEL_HI:F_SEL_LO];
	assign range_unipolar = cfg_act_q[F_UNI];
	assign range_gain = cfg_act_q[F_GAIN];
	assign nap_mode = cfg_act_q[F_NAP];
	assign sleep_mode = cfg_act_q[F_SLEEP];

	// Pin outputs
	assign sdo_o = ser.sdo_bit;
	assign sdo_oe = !rd_b;
	assign busy_b = busy_b_q;
	assign sample_hold = hold_q;
	assign dac_code = sar.dac_code;
	assign acq_short = acq_short_q;
	assign result_word = result_q;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	sequence s_launch;
		conv_edge && (state_q != ST_CONV);
	endsequence

	sequence s_finish;
		sar.done && (state_q == ST_CONV);
	endsequence

	sequence s_conv_run;
		(state_q == ST_CONV) && !sar.done;
	endsequence

	a_read_gate: assert property (
		sdo_oe == !rd_b)
		else $error("serial output enable does not follow read enable");

	a_conv_launch: assert property (
		s_launch |=> (state_q == ST_CONV) && !busy_b)
		else $error("convert start edge did not begin a conversion");

	a_hold_enter: assert property (
		s_launch |=> sample_hold ##1 sample_hold)
		else $error("sample not held at conversion start");

	a_no_restart: assert property (
		(state_q == ST_CONV) && conv_edge && !sar.done |->
		!sar.start ##1 (state_q == ST_CONV))
		else $error("running conversion was restarted");

	a_busy_low: assert property (
		s_launch ##1 (state_q == ST_CONV) |-> !busy_b)
		else $error("busy high during conversion");

	a_busy_release: assert property (
		s_finish |=> busy_b && (state_q == ST_IDLE))
		else $error("busy not released at completion");

	a_unipolar_code: assert property (
		(s_finish and range_unipolar) |=> result_word == $past(sar.result))
		else $error("unipolar result is not natural binary");

	a_bipolar_code: assert property (
		(s_finish and !range_unipolar) |=>
		result_word == ($past(sar.result) ^ SAR_MSB))
		else $error("bipolar result is not two's complement");

	a_cfg_apply: assert property (
		cfg_edge && (state_q != ST_CONV) |=>
		(chan_sel == $past(ser.cfg_word[F_SEL_HI:F_SEL_LO])) &&
		(range_unipolar == $past(ser.cfg_word[F_UNI])))
		else $error("config word not applied");

	a_acq_enter: assert property (
		acq_edge && !conv_edge && (state_q == ST_IDLE) |=>
		(state_q == ST_ACQ) && !sample_hold)
		else $error("acquisition did not start");

	a_link_frozen: assert property (
		s_launch ##1 (state_q == ST_CONV) ##1 (state_q == ST_CONV)
		|-> !link_en_q)
		else $error("serial link active during conversion");

	a_busy_span: assert property (
		s_launch |=> !busy_b [*8])
		else $error("busy not held low after conversion start");

	a_hold_steady: assert property (
		(state_q == ST_CONV) |-> sample_hold)
		else $error("sampler left hold during conversion");

	a_cfg_steady: assert property (
		(state_q == ST_CONV) |=> $stable(range_unipolar) && $stable(chan_sel))
		else $error("config changed during conversion");

	a_result_steady: assert property (
		s_conv_run |=> $stable(result_word))
		else $error("result word changed before completion");

	a_link_release: assert property (
		s_finish |-> ##2 link_en_q)
		else $error("serial link not released after completion");
endmodule : msc_top

// [tb/msc_host_model.sv]
// Host serial port model driving full duplex frames
`timescale 1ns/1ps
module msc_host_model (
	// Serial link
	output logic sck,
	output logic sdi,
	input wire logic sdo,
	input wire logic sdo_oe
);
	logic [15:0] rx;
	logic oe_any;
	initial
	begin
		sck = 1'b0;
		sdi = 1'b0;
		rx = 16'h0000;
		oe_any = 1'b0;
	end
	// One frame of 16 clocks at 15 ns, clock still outside frames
	task automatic frame(input logic [7:0] cfg);
		int k;
		#3.3;
		oe_any = 1'b0;
		sdi = cfg[7];
		for (k = 1; k <= 16; k++)
		begin
			#7.5;
			sck = 1'b1;
			rx[16-k] = sdo;
			oe_any = oe_any | sdo_oe;
			#7.5;
			sck = 1'b0;
			// Pad bits after the word keep toggling
			sdi = (k < 8) ? cfg[7-k] : ~sdi;
		end
	endtask : frame
endmodule : msc_host_model

// [tb/msc_top_tb_top.sv]
// Self-checking bench of the serial ADC control block
`timescale 1ns/1ps
module msc_top_tb_top;
	import msc_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic rd_b = 1'b0;
	logic convert_start = 1'b0;
	logic comp_hi = 1'b0;
	logic [15:0] vin = 16'h0000;
	logic sdo_last = 1'b0;
	logic sck, sdi, sdo_o, sdo_oe, sdo_w, busy_b, sample_hold, acq_short;
	logic sgl, odd, uni, gain, nap, slp;
	logic [1:0] sel;
	logic [7:0] cfg_seen;
	logic [15:0] dac_code, result_word;
	int err_count = 0;
	int n_tests = 0;
	always #4 clk = ~clk;
	// Ideal comparator: input at or above the trial code
	always @(posedge clk) comp_hi <= (dac_code <= vin);
	always @* if (sdo_oe) sdo_last = sdo_o;
	// Released line shows the inverse of its last value
	assign sdo_w = sdo_oe ? sdo_o : ~sdo_last;
	assign cfg_seen = {sgl, odd, sel, uni, gain, nap, slp};
	msc_top dut_u (.clk(clk), .rst_b(rst_b), .sck(sck), .sdi(sdi),
		.rd_b(rd_b), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
		.convert_start(convert_start), .busy_b(busy_b), .comp_hi(comp_hi),
		.dac_code(dac_code), .sample_hold(sample_hold),
		.single_or_differential_select(sgl), .odd_sign(odd),
		.chan_sel(sel), .range_unipolar(uni), .range_gain(gain),
		.nap_mode(nap), .sleep_mode(slp), .acq_short(acq_short),
		.result_word(result_word));
	msc_host_model host_u (.sck(sck), .sdi(sdi), .sdo(sdo_w),
		.sdo_oe(sdo_oe));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_count++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic end_sim;
		$display("Comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_sim
	// Frame, acquisition, conversion and result checks
	task automatic run_conv(input logic [7:0] cfg, input logic [15:0] v,
		input logic [15:0] prev, input int acq, input bit poke);
		int n;
		logic [15:0] exp;
		exp = cfg[F_UNI] ? v : v ^ SAR_MSB;
		host_u.frame(cfg);
		if (rd_b === 1'b0)
			chk(host_u.rx, prev);
		repeat (4) @(negedge clk);
		chk(16'(cfg_seen), 16'(cfg));
		chk(16'(sample_hold), 16'h0000);
		repeat (acq) @(posedge clk);
		vin <= v;
		convert_start <= 1'b1;
		repeat (4) @(posedge clk);
		convert_start <= 1'b0;
		n = 4;
		while (busy_b !== 1'b0 && n < 12)
		begin
			@(negedge clk);
			n++;
		end
		chk(16'(n < 12), 16'h0001);
		chk(16'(sample_hold), 16'h0001);
		chk(dac_code, SAR_MSB);
		n = 0;
		while (busy_b === 1'b0 && n < 2000)
		begin
			@(negedge clk);
			n++;
			if (poke && n == 100)
				@(posedge clk) convert_start <= 1'b1;
			if (poke && n == 104)
				@(posedge clk) convert_start <= 1'b0;
			if (n == BIT_CYC + BIT_CYC / 2)
				chk(dac_code, {v[15], 15'h4000});
		end
		chk(16'(n >= 16 * BIT_CYC && n <= 16 * BIT_CYC + 6), 16'h0001);
		chk(result_word, exp);
		chk(16'(acq_short), 16'(acq < ACQ_MIN_CYC));
		repeat (2) @(negedge clk);
		if (rd_b === 1'b0)
			chk(16'(sdo_w), 16'(exp[15]));
	endtask : run_conv
	task automatic t_reset;
		chk(16'({busy_b, sample_hold, acq_short}), 16'h0004);
		chk(result_word, RES_ZERO);
		chk(dac_code, RES_ZERO);
		chk(16'(cfg_seen), 16'(CFG_RST));
		chk(16'(sdo_oe), 16'h0001);
		$display("t_reset done");
	endtask : t_reset
	task automatic t_mid_reset;
		@(posedge clk) convert_start <= 1'b1;
		repeat (4) @(posedge clk);
		convert_start <= 1'b0;
		repeat (50) @(negedge clk);
		chk(16'(busy_b), 16'h0000);
		@(posedge clk) rst_b <= 1'b0;
		repeat (2) @(negedge clk);
		chk(16'({busy_b, sample_hold, acq_short}), 16'h0004);
		chk(result_word, RES_ZERO);
		chk(dac_code, RES_ZERO);
		@(posedge clk) rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		run_conv(8'hB8, 16'h00F0, RES_ZERO, ACQ_MIN_CYC, 1'b0);
		$display("t_mid_reset done");
	endtask : t_mid_reset
	task automatic t_unipolar;
		run_conv(8'hB8, 16'h1234, RES_ZERO, ACQ_MIN_CYC, 1'b0);
		$display("t_unipolar done");
	endtask : t_unipolar
	task automatic t_bipolar_top_restart;
		run_conv(8'h66, 16'hFFFF, 16'h1234, ACQ_MIN_CYC, 1'b1);
		$display("t_bipolar_top_restart done");
	endtask : t_bipolar_top_restart
	task automatic t_bipolar_neg_short;
		run_conv(8'h51, 16'h7FFF, 16'h7FFF, 20, 1'b0);
		$display("t_bipolar_neg_short done");
	endtask : t_bipolar_neg_short
	task automatic t_read_gate;
		@(posedge clk) rd_b <= 1'b1;
		run_conv(8'hCD, 16'hA5C3, 16'hFFFF, ACQ_MIN_CYC, 1'b0);
		chk(16'(host_u.oe_any), 16'h0000);
		@(posedge clk) rd_b <= 1'b0;
		repeat (3) @(negedge clk);
		chk(16'(sdo_oe), 16'h0001);
		host_u.frame(8'h00);
		chk(host_u.rx, 16'hA5C3);
		$display("t_read_gate done");
	endtask : t_read_gate
	initial
	begin
		repeat (3) @(posedge clk);
		t_reset;
		@(posedge clk) rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		t_unipolar;
		t_bipolar_top_restart;
		t_bipolar_neg_short;
		t_read_gate;
		t_mid_reset;
		end_sim;
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		err_count++;
		$display("ERROR %0t watchdog expired", $time);
		end_sim;
	end
endmodule : msc_top_tb_top
